//--- hw/mih_header_gen.v
// Contract
// - Stack off: flow packets carry no shim header.
// - Single or double stack inserts exactly one or two shim headers.
// - Top traffic class goes into top header, only with double stack.
// - Top TTL goes into top header, only with double stack.
// - Traffic class fields hold exactly three bits.
// - Local profile is held and used as endpoint regardless of stream source.
// - Internal local address stays independent of custom stream addresses.
// - ARP and echo answered only for local profile address and VID.
// - Local origin puts the local profile address as stream source.
// - Manual origin puts the configured manual address in every packet.
// - Remote origin only in asymmetric downstream tests; uses far end address.
// - Opposite origin selects the other port of the same unit.
// - Manual source accepts any 32-bit value.
// - Bottom label goes into bottom header for single or double stack.
// - Eight flows keep independent label stack settings.
`timescale 1ns/100ps
`include "mih_regs.vh"

module mih_fifo #(
  parameter WIDTH = 33,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Fill side
  input wire inValid,
  input wire [WIDTH-1:0] inData,
  output wire inReady,
  // Drain side
  output wire outValid,
  output wire [WIDTH-1:0] outData,
  input wire outReady
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_q;
  reg [AW-1:0] rdPtr_q;
  reg [AW:0] count_q;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;

  assign inReady = (count_q != DEPTH[AW:0]);
  assign outValid = (count_q != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_q];

  always @(posedge clock) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // mih_fifo

module mih_header_gen (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // APB register port
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Packet header request
  input wire pktReqValid,
  input wire [2:0] pktReqFlow,
  output wire pktReqReady,
  // Header word stream toward the framer
  output wire hdrValid,
  output wire [31:0] hdrData,
  output wire hdrLast,
  input wire hdrReady,
  // Received ARP / echo requests
  input wire echoReqValid,
  input wire echoReqIsArp,
  input wire [31:0] echoReqIp,
  input wire [11:0] echoReqVid,
  // Reply permission
  output wire echoReplyValid,
  output wire echoReplyIsArp
);
  localparam S_IDLE = 2'h0;
  localparam S_TOP = 2'h1;
  localparam S_BOT = 2'h2;
  localparam S_SRC = 2'h3;

  reg [1:0] ctrl_q;
  reg [31:0] localIp_q;
  reg [11:0] localVid_q;
  reg [31:0] remoteIp_q;
  reg [31:0] oppIp_q;
  reg [15:0] pktCount_q;
  reg [15:0] echoCount_q;
  reg [31:0] prdata_q;
  reg echoReply_q;
  reg echoArp_q;

  reg [1:0] state_q;
  reg [1:0] stack_q;
  reg [31:0] topWord_q;
  reg [31:0] botWord_q;
  reg [31:0] srcWord_q;

  wire [3:0] flowCfgW [0:`MIH_FLOWS-1];
  wire [31:0] flowBotW [0:`MIH_FLOWS-1];
  wire [31:0] flowTopW [0:`MIH_FLOWS-1];
  wire [31:0] flowManW [0:`MIH_FLOWS-1];

  // Address decode
  wire access = psel && penable;
  wire flowHit = (paddr[11:7] == `MIH_FLOW_TAG);
  wire [2:0] flowIdx = paddr[6:4];
  wire [1:0] flowReg = paddr[3:2];
  wire aligned = (paddr[1:0] == 2'b00);
  reg mapped;
  reg refused;

  // Global registers fill every aligned word up to STATUS
  always @* begin
    mapped = 1'b0;
    if (aligned && (flowHit || paddr <= `MIH_STATUS)) begin
      mapped = 1'b1;
    end
  end

  // Reserved stack code and remote origin outside asymmetric tests are refused
  always @* begin
    refused = 1'b0;
    if (pwrite && flowHit && flowReg == `MIH_FLOW_CFG) begin
      if (pwdata[`MIH_CFG_STACK_LSB+:2] == 2'h3) begin
        refused = 1'b1;
      end else if (pwdata[`MIH_CFG_ORIGIN_LSB+:2] == `MIH_ORIGIN_REMOTE &&
                   !ctrl_q[`MIH_CTRL_ASYM]) begin
        refused = 1'b1;
      end
    end
    if (pwrite && paddr == `MIH_STATUS) begin
      refused = 1'b1;
    end
  end

  wire wrEn = access && pwrite && mapped && !refused;
  wire flowWr = wrEn && flowHit;

  assign pready = 1'b1;
  assign pslverr = access && (!mapped || refused);
  assign prdata = prdata_q;

  // Global registers; local profile kept apart from any stream address
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `MIH_CTRL_RST;
      localIp_q <= `MIH_WORD_RST;
      localVid_q <= `MIH_VID_RST;
      remoteIp_q <= `MIH_WORD_RST;
      oppIp_q <= `MIH_WORD_RST;
    end else if (wrEn && !flowHit) begin
      if (paddr == `MIH_CTRL) begin
        ctrl_q <= pwdata[1:0];
      end else if (paddr == `MIH_LOCAL_IP) begin
        localIp_q <= pwdata;
      end else if (paddr == `MIH_LOCAL_VID) begin
        localVid_q <= pwdata[11:0];
      end else if (paddr == `MIH_REMOTE_IP) begin
        remoteIp_q <= pwdata;
      end else if (paddr == `MIH_OPP_IP) begin
        oppIp_q <= pwdata;
      end
    end
  end

  // Per-flow settings, each flow its own copy
  genvar g;
  generate
    for (g = 0; g < `MIH_FLOWS; g = g + 1) begin : gFlow
      localparam [2:0] IDX = g;
      reg [3:0] cfg_q;
      reg [31:0] bot_q;
      reg [31:0] top_q;
      reg [31:0] man_q;
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          cfg_q <= `MIH_CFG_RST;
          bot_q <= `MIH_WORD_RST;
          top_q <= `MIH_WORD_RST;
          man_q <= `MIH_WORD_RST;
        end else if (flowWr && flowIdx == IDX) begin
          case (flowReg)
            `MIH_FLOW_CFG: cfg_q <= pwdata[3:0];
            `MIH_FLOW_BOT: bot_q <= pwdata & `MIH_SHIM_MASK;
            `MIH_FLOW_TOP: top_q <= pwdata & `MIH_SHIM_MASK;
            default: man_q <= pwdata;
          endcase
        end
      end
      assign flowCfgW[g] = cfg_q;
      assign flowBotW[g] = bot_q;
      assign flowTopW[g] = top_q;
      assign flowManW[g] = man_q;
    end
  endgenerate

  // Read data registered in the setup phase, valid through the access phase
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= `MIH_WORD_RST;
    end else if (psel && !penable) begin
      prdata_q <= `MIH_WORD_RST;
      if (aligned && flowHit) begin
        case (flowReg)
          `MIH_FLOW_CFG: prdata_q <= {28'h0000000, flowCfgW[flowIdx]};
          `MIH_FLOW_BOT: prdata_q <= flowBotW[flowIdx];
          `MIH_FLOW_TOP: prdata_q <= flowTopW[flowIdx];
          default: prdata_q <= flowManW[flowIdx];
        endcase
      end else if (paddr == `MIH_CTRL) begin
        prdata_q <= {30'h00000000, ctrl_q};
      end else if (paddr == `MIH_LOCAL_IP) begin
        prdata_q <= localIp_q;
      end else if (paddr == `MIH_LOCAL_VID) begin
        prdata_q <= {20'h00000, localVid_q};
      end else if (paddr == `MIH_REMOTE_IP) begin
        prdata_q <= remoteIp_q;
      end else if (paddr == `MIH_OPP_IP) begin
        prdata_q <= oppIp_q;
      end else if (paddr == `MIH_STATUS) begin
        prdata_q <= {echoCount_q, pktCount_q};
      end
    end
  end

  // Header builder
  wire fifoInReady;
  wire [3:0] reqCfg = flowCfgW[pktReqFlow];
  wire [1:0] reqStack = reqCfg[`MIH_CFG_STACK_LSB+:2];
  wire [1:0] reqOrigin = reqCfg[`MIH_CFG_ORIGIN_LSB+:2];
  wire start = pktReqValid && (state_q == S_IDLE);
  wire emit = (state_q != S_IDLE) && fifoInReady;
  reg [31:0] srcSel;
  reg [31:0] emitWord;

  always @* begin
    case (reqOrigin)
      `MIH_ORIGIN_MANUAL: srcSel = flowManW[pktReqFlow];
      // A flow left on remote after asymmetric mode ends reverts to local
      `MIH_ORIGIN_REMOTE: srcSel = ctrl_q[`MIH_CTRL_ASYM] ? remoteIp_q : localIp_q;
      `MIH_ORIGIN_OPPOSITE: srcSel = oppIp_q;
      default: srcSel = localIp_q;
    endcase
  end

  always @* begin
    case (state_q)
      S_TOP: emitWord = topWord_q;
      S_BOT: emitWord = botWord_q;
      default: emitWord = srcWord_q;
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      stack_q <= `MIH_STACK_OFF;
      topWord_q <= `MIH_WORD_RST;
      botWord_q <= `MIH_WORD_RST;
      srcWord_q <= `MIH_WORD_RST;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (start) begin
            // Settings frozen per packet so writes never split a header
            stack_q <= reqStack;
            topWord_q <= flowTopW[pktReqFlow];
            botWord_q <= flowBotW[pktReqFlow] | (32'h1 << `MIH_SHIM_BOS);
            srcWord_q <= srcSel;
            if (reqStack == `MIH_STACK_DOUBLE) begin
              state_q <= S_TOP;
            end else if (reqStack == `MIH_STACK_SINGLE) begin
              state_q <= S_BOT;
            end else begin
              state_q <= S_SRC;
            end
          end
        end
        S_TOP, S_BOT: begin
          // Shim states sit in code order just below the source word
          if (emit) begin
            state_q <= state_q + 2'h1;
          end
        end
        default: begin
          if (emit) begin
            state_q <= S_IDLE;
          end
        end
      endcase
    end
  end

  assign pktReqReady = (state_q == S_IDLE);

  mih_fifo #(
    .WIDTH(33),
    .DEPTH(4),
    .AW(2)
  ) uFifo (
    .clock(clock),
    .rst_n(rst_n),
    .inValid(state_q != S_IDLE),
    .inData({state_q == S_SRC, emitWord}),
    .inReady(fifoInReady),
    .outValid(hdrValid),
    .outData({hdrLast, hdrData}),
    .outReady(hdrReady)
  );

  // Echo and ARP answered only for the local profile, endpoint mode only
  wire echoMatch = echoReqValid && ctrl_q[`MIH_CTRL_HOST] &&
                   echoReqIp == localIp_q && echoReqVid == localVid_q;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      echoReply_q <= 1'b0;
      echoArp_q <= 1'b0;
      pktCount_q <= 16'h0000;
      echoCount_q <= 16'h0000;
    end else begin
      echoReply_q <= echoMatch;
      echoArp_q <= echoMatch && echoReqIsArp;
      if (echoMatch) begin
        echoCount_q <= echoCount_q + 16'h0001;
      end
      if (emit && state_q == S_SRC) begin
        pktCount_q <= pktCount_q + 16'h0001;
      end
    end
  end

  assign echoReplyValid = echoReply_q;
  assign echoReplyIsArp = echoArp_q;
endmodule // mih_header_gen

//--- hw/mih_regs.vh
`ifndef MIH_REGS_VH
`define MIH_REGS_VH

// Byte addresses of the global registers
`define MIH_ADDR_W 12
`define MIH_CTRL 12'h000
`define MIH_LOCAL_IP 12'h004
`define MIH_LOCAL_VID 12'h008
`define MIH_REMOTE_IP 12'h00C
`define MIH_OPP_IP 12'h010
`define MIH_STATUS 12'h014

// Per-flow window: base 0x100, 16 bytes per flow, eight flows
`define MIH_FLOW_TAG 5'h02
`define MIH_FLOWS 8
`define MIH_FLOW_CFG 2'h0
`define MIH_FLOW_BOT 2'h1
`define MIH_FLOW_TOP 2'h2
`define MIH_FLOW_MAN 2'h3

// CTRL fields
`define MIH_CTRL_HOST 0
`define MIH_CTRL_ASYM 1

// FLOW_CFG fields
`define MIH_CFG_STACK_LSB 0
`define MIH_CFG_ORIGIN_LSB 2

// Label stack depth codes
`define MIH_STACK_OFF 2'h0
`define MIH_STACK_SINGLE 2'h1
`define MIH_STACK_DOUBLE 2'h2

// Source address origin codes
`define MIH_ORIGIN_LOCAL 2'h0
`define MIH_ORIGIN_MANUAL 2'h1
`define MIH_ORIGIN_REMOTE 2'h2
`define MIH_ORIGIN_OPPOSITE 2'h3

// Shim word layout: label 31:12, class 11:9, bottom flag 8, ttl 7:0
`define MIH_SHIM_BOS 8
`define MIH_SHIM_MASK 32'hFFFFFEFF

// Reset values
`define MIH_CTRL_RST 2'h0
`define MIH_WORD_RST 32'h00000000
`define MIH_VID_RST 12'h000
`define MIH_CFG_RST 4'h0

`endif

//--- bench/mih_hdr_assertions.sv
`timescale 1ns/100ps
module mih_hdr_assertions (
  // Clock and reset
  input logic clock,
  input logic rst_n,
  // Requests and header words
  input logic pktReqValid,
  input logic pktReqReady,
  input logic hdrValid,
  input logic [31:0] hdrData,
  input logic hdrLast,
  input logic hdrReady,
  // Echo gate
  input logic echoReqValid,
  input logic echoReqIsArp,
  input logic echoReplyValid,
  input logic echoReplyIsArp
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic afterTop_q;
  logic afterBot_q;
  logic [1:0] shimCnt_q;
  wire take = hdrValid && hdrReady;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      afterTop_q <= 1'b0;
      afterBot_q <= 1'b0;
      shimCnt_q <= 2'h0;
    end else if (take) begin
      afterTop_q <= !hdrLast && !hdrData[8];
      afterBot_q <= !hdrLast && hdrData[8];
      shimCnt_q <= hdrLast ? 2'h0 : shimCnt_q + 2'h1;
    end
  end
  sequence reqTaken;
    pktReqValid && pktReqReady;
  endsequence
  sequence lastOut;
    hdrValid && hdrLast;
  endsequence
  AST_HOLD: assert property (hdrValid && !hdrReady |=>
    hdrValid && $stable(hdrData) && $stable(hdrLast)) else $error("header word moved");
  AST_TOP_BOT: assert property (take && afterTop_q |-> hdrData[8] && !hdrLast)
    else $error("top shim not followed by bottom");
  AST_BOT_SRC: assert property (take && afterBot_q |-> hdrLast)
    else $error("bottom shim not followed by source");
  AST_COUNT: assert property (take && shimCnt_q == 2'h2 |-> hdrLast)
    else $error("more than two shims");
  AST_BUSY: assert property (reqTaken |=> !pktReqReady)
    else $error("builder ready right after take");
  AST_LATENCY: assert property (reqTaken |-> ##[2:60] lastOut)
    else $error("header never completed");
  AST_ECHO_COPY: assert property (echoReplyValid |->
    $past(echoReqValid) && echoReplyIsArp == $past(echoReqIsArp)) else $error("bad reply");
  AST_ECHO_NONE: assert property (!echoReqValid |=> !echoReplyValid)
    else $error("reply without request");
  AST_ISARP_ZERO: assert property (!echoReplyValid |-> !echoReplyIsArp)
    else $error("arp flag without reply");
endmodule // mih_hdr_assertions

bind mih_header_gen mih_hdr_assertions u_chk (.clock(clock), .rst_n(rst_n),
  .pktReqValid(pktReqValid), .pktReqReady(pktReqReady), .hdrValid(hdrValid),
  .hdrData(hdrData), .hdrLast(hdrLast), .hdrReady(hdrReady), .echoReqValid(echoReqValid),
  .echoReqIsArp(echoReqIsArp), .echoReplyValid(echoReplyValid),
  .echoReplyIsArp(echoReplyIsArp));

//--- bench/mih_net_model.sv
`timescale 1ns/100ps
module mih_net_model (
  // Clock and reset
  input logic clock,
  input logic rst_n,
  // Header stream
  input logic hdrValid,
  input logic [31:0] hdrData,
  input logic hdrLast,
  output logic hdrReady,
  // Pacing
  input logic stall,
  input logic fast,
  // Hop result
  output logic dropped
);
  logic phase_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= !phase_q;
    end
  end
  // Slow mode accepts every other cycle
  assign hdrReady = !stall && (fast || phase_q);
  // Hop lowers shim TTL by one, lost at zero
  assign dropped = hdrValid && hdrReady && !hdrLast && (hdrData[7:0] == 8'h01);
endmodule // mih_net_model

//--- bench/testbench.sv
`timescale 1ns/100ps
`include "mih_regs.vh"
module testbench;
  logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pktReqValid = 1'b0, echoReqValid = 1'b0, echoReqIsArp = 1'b0, stall = 1'b0;
  logic fast = 1'b1, pktReqReady, hdrValid, hdrLast, hdrReady, pready, pslverr, er;
  logic echoReplyValid, echoReplyIsArp;
  logic [11:0] paddr = 12'h000, echoReqVid = 12'h000;
  logic [2:0] pktReqFlow = 3'h0;
  logic [31:0] pwdata = 32'h0, echoReqIp = 32'h0, prdata, hdrData, rd;
  logic [32:0] got[$], exp[$];
  int errors, checkCount, cyc;
  localparam logic [31:0] LOC = 32'hC0A80001, REM = 32'h0A000002, OPP = 32'hAC100003;
  localparam logic [11:0] VID = 12'h05A;
  logic [3:0] rowCfg [8] = '{4'h0, 4'h5, 4'h6, 4'hE, 4'h9, 4'hC, 4'h2, 4'h4};
  logic [31:0] rowMan [8] = '{32'h1, 32'h0, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h2};
  mih_header_gen DUT (.clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pktReqValid(pktReqValid), .pktReqFlow(pktReqFlow),
    .pktReqReady(pktReqReady), .hdrValid(hdrValid), .hdrData(hdrData), .hdrLast(hdrLast),
    .hdrReady(hdrReady), .echoReqValid(echoReqValid), .echoReqIsArp(echoReqIsArp),
    .echoReqIp(echoReqIp), .echoReqVid(echoReqVid), .echoReplyValid(echoReplyValid),
    .echoReplyIsArp(echoReplyIsArp));
  mih_net_model net (.clock(clock), .rst_n(rst_n), .hdrValid(hdrValid), .hdrData(hdrData),
    .hdrLast(hdrLast), .hdrReady(hdrReady), .stall(stall), .fast(fast), .dropped());
  initial begin
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    if (rst_n && hdrValid && hdrReady) got.push_back({hdrLast, hdrData});
    cyc++;
    if (cyc == 6000) begin
      errors++;
      final_report;
    end
  end
  function logic [31:0] bv(input int f);
    return 32'hC3C3C0AA + (f << 12);
  endfunction
  function logic [31:0] tv(input int f);
    return 32'h5A5A5FFF + (f << 12);
  endfunction
  task chk(input logic [32:0] seen, input logic [32:0] want);
    checkCount++;
    if (seen !== want) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (!pready) @(posedge clock);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task pkt(input int f);
    logic [1:0] org;
    @(posedge clock);
    pktReqValid <= 1'b1;
    pktReqFlow <= f[2:0];
    @(posedge clock);
    while (!pktReqReady) @(posedge clock);
    pktReqValid <= 1'b0;
    org = rowCfg[f][3:2];
    if (rowCfg[f][1:0] == `MIH_STACK_DOUBLE) exp.push_back({1'b0, tv(f) & `MIH_SHIM_MASK});
    if (rowCfg[f][1:0] != `MIH_STACK_OFF) exp.push_back({1'b0, bv(f) | 32'h100});
    exp.push_back({1'b1, org == 0 ? LOC : org == 1 ? rowMan[f] : org == 2 ? REM : OPP});
  endtask
  task drain;
    while (got.size() < exp.size()) @(posedge clock);
    while (exp.size() > 0) chk(got.pop_front(), exp.pop_front());
  endtask
  task echo(input logic [31:0] ip, input logic [11:0] vid, input logic arp, input logic hit);
    @(posedge clock);
    echoReqValid <= 1'b1;
    echoReqIp <= ip;
    echoReqVid <= vid;
    echoReqIsArp <= arp;
    @(posedge clock);
    echoReqValid <= 1'b0;
    @(posedge clock);
    chk({echoReplyValid, echoReplyIsArp}, {hit, hit & arp});
  endtask
  task final_report;
    $display("errors=%0d checkCount=%0d", errors, checkCount);
    if (errors == 0 && checkCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    chk(hdrValid, 1'b0);
    apb({4'h1, 4'h4, 4'h0}, 1'b1, 32'h9);
    chk(er, 1'b1);
    apb(12'h100, 1'b1, 32'h3);
    chk(er, 1'b1);
    apb(12'h020, 1'b0, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    apb(`MIH_CTRL, 1'b1, 32'h3);
    apb(`MIH_LOCAL_IP, 1'b1, LOC);
    apb(`MIH_LOCAL_VID, 1'b1, {20'h0, VID});
    apb(`MIH_REMOTE_IP, 1'b1, REM);
    apb(`MIH_OPP_IP, 1'b1, OPP);
    for (int f = 0; f < 8; f++) begin
      apb({4'h1, f[3:0], 4'h0}, 1'b1, {28'h0, rowCfg[f]});
      apb({4'h1, f[3:0], 4'h4}, 1'b1, bv(f));
      apb({4'h1, f[3:0], 4'h8}, 1'b1, tv(f));
      apb({4'h1, f[3:0], 4'hC}, 1'b1, rowMan[f]);
    end
    for (int f = 0; f < 8; f++) begin
      apb({4'h1, f[3:0], 4'h0}, 1'b0, 32'h0);
      chk(rd, {28'h0, rowCfg[f]});
      fast <= f[0];
      pkt(f);
      drain;
    end
    // Second header stalls after its top shim, behind a stalled, full queue
    stall <= 1'b1;
    pkt(2);
    pkt(6);
    repeat (20) @(posedge clock);
    chk(pktReqReady, 1'b0);
    stall <= 1'b0;
    drain;
    apb(`MIH_STATUS, 1'b0, 32'h0);
    chk(rd[15:0], 16'h000A);
    echo(LOC, VID, 1'b1, 1'b1);
    echo(LOC, VID, 1'b0, 1'b1);
    echo(LOC ^ 32'h1, VID, 1'b1, 1'b0);
    echo(LOC, VID ^ 12'h1, 1'b0, 1'b0);
    apb(`MIH_CTRL, 1'b1, 32'h0);
    echo(LOC, VID, 1'b1, 1'b0);
    // Counters are read-only, and two echoes matched
    apb(`MIH_STATUS, 1'b1, 32'hFFFFFFFF);
    chk(er, 1'b1);
    apb(`MIH_STATUS, 1'b0, 32'h0);
    chk(rd, {16'h0002, 16'h000A});
    // Mid-run reset clears the profile and the flow settings
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    apb(`MIH_LOCAL_IP, 1'b0, 32'h0);
    chk(rd, 32'h0);
    apb(12'h120, 1'b0, 32'h0);
    chk(rd, 32'h0);
    final_report;
  end
endmodule // testbench
